// ---- include/scan_defs.svh ----
// constants for the test-port data-register block
`ifndef SCAN_DEFS_SVH
`define SCAN_DEFS_SVH
`define IR_WIDTH 4
`define OP_EXTEST 4'h0
`define OP_IDCODE 4'h1
`define OP_SAMPLE 4'h2
`define OP_PRIV_A 4'h8
`define OP_PRIV_B 4'h9
`define OP_PRIV_C 4'hA
`define OP_PRIV_D 4'hB
`define OP_SYSRST 4'hC
`define OP_BYPASS 4'hF
`define IR_CAPTURE 4'h1
`define ID_WIDTH 32
`define ID_VER_LSB 28
`define ID_PART_LSB 12
`define ID_MAKER_LSB 1
`define BSC_LEN 8
`define DMR_DIRTY_BIT 7
`define TIMEOUT_NS 65000
`define TIMEOUT_CYC ((`TIMEOUT_NS + 9) / 10)
`endif

// ---- include/scan_pkg.sv ----
// types for the test-port data-register block
package scan_pkg;
  typedef enum logic [15:0] {
    TLR = 16'h0001, RTI = 16'h0002, SEL_DR = 16'h0004, CAP_DR = 16'h0008,
    SH_DR = 16'h0010, EX1_DR = 16'h0020, PA_DR = 16'h0040,
    EX2_DR = 16'h0080, UPD_DR = 16'h0100, SEL_IR = 16'h0200,
    CAP_IR = 16'h0400, SH_IR = 16'h0800, EX1_IR = 16'h1000,
    PA_IR = 16'h2000, EX2_IR = 16'h4000, UPD_IR = 16'h8000
  } tap_state_type;
  typedef struct packed {
    logic tck;
    logic tms;
    logic tdi;
  } tap_pins_type;
  typedef struct packed {
    logic [7:0] addr_match;
    logic wr;
    logic rd;
    logic [7:0] wdata;
  } io_req_type;
endpackage : scan_pkg

// ---- design/sync2.sv ----
// two-flop synchroniser
`timescale 1ns/1ns
`default_nettype none
module sync2
(
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // data
  input wire logic d,
  output logic q
);
  logic meta;
  // first stage read only by the second
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      meta <= 1'b0;
      q <= 1'b0;
    end
    else
    begin
      meta <= d;
      q <= meta;
    end
  end
endmodule : sync2
`default_nettype wire

// ---- design/scan_data_regs.sv ----
// test-port data registers, debug message register and access gating
`timescale 1ns/1ns
`default_nettype none
`include "scan_defs.svh"
module scan_data_regs
#(
  parameter logic [3:0] VERSION = 4'h0,    // revision A
  parameter logic [15:0] PART_NUMBER = 16'h1234, // arbitrary value
  parameter logic [10:0] MAKER_CODE = 11'h055,  // arbitrary value
  parameter int TIMEOUT_CYCLES = `TIMEOUT_CYC
)
(
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // test port pins
  input wire logic tck,
  input wire logic tms,
  input wire logic tdi,
  output logic tdo,
  output logic tdo_oe,
  // fuses and lock bits
  input wire logic test_port_enable_fuse,
  input wire logic debug_enable_fuse,
  input wire logic lock_bit_one,
  input wire logic lock_bit_two,
  input wire logic chip_erase_done,
  input wire logic fuse_prog_req,
  output logic fuse_prog_grant,
  // processor control
  input wire logic test_port_disable_bit,
  input wire logic debugger_access_en,
  // processor io port at the shared address
  input wire logic io_sel,
  input wire logic io_wr,
  input wire logic io_rd,
  input wire logic [7:0] io_wdata,
  output logic [7:0] io_rdata,
  output logic io_ordinary_sel,
  // debugger side of the message register
  input wire logic dbg_read_ack,
  output logic [7:0] dbg_message,
  // external reset pin and system reset
  input wire logic ext_rst_n,
  output logic system_reset,
  // boundary scan pins
  input wire logic [`BSC_LEN-1:0] pin_in,
  input wire logic [`BSC_LEN-1:0] core_out,
  input wire logic [`BSC_LEN-1:0] core_oe,
  output logic [`BSC_LEN-1:0] pin_out,
  output logic [`BSC_LEN-1:0] pin_oe,
  // debug path
  output logic debug_path_sel,
  output logic [3:0] instruction
);
  // ************************************************************
  // state
  // ************************************************************
  typedef struct packed {
    scan_pkg::tap_state_type st;
    logic tck_d;
    logic [3:0] ir_sh;
    logic [3:0] ir;
    logic [31:0] dr_sh;
    logic bypass;
    logic rst_reg;
    logic [`BSC_LEN-1:0] bsc_sh;
    logic [`BSC_LEN-1:0] bsc_latch;
    logic [6:0] msg;
    logic dirty;
    logic erased;
    logic [31:0] tmo;
    logic tdo;
  } state_type;
  state_type r;
  state_type next_r;
  logic tck_s;
  logic tms_s;
  logic tdi_s;
  logic rst_pin_n_s;
  logic tck_rise;
  logic tck_fall;
  logic port_on;
  logic dmr_hit;
  logic boundary_sel;
  logic [31:0] id_word;
  // ************************************************************
  // pin synchronisers
  // ************************************************************
  sync2 u_tck (.clk(clk), .sys_rst(sys_rst), .d(tck), .q(tck_s));
  sync2 u_tms (.clk(clk), .sys_rst(sys_rst), .d(tms), .q(tms_s));
  sync2 u_tdi (.clk(clk), .sys_rst(sys_rst), .d(tdi), .q(tdi_s));
  sync2 u_rst (.clk(clk), .sys_rst(sys_rst), .d(ext_rst_n),
    .q(rst_pin_n_s));
  // ************************************************************
  // combinational decode
  // ************************************************************
  // tck must stay below half of clk for edge sampling to work
  assign tck_rise = tck_s & ~r.tck_d;
  assign tck_fall = ~tck_s & r.tck_d;
  assign port_on = test_port_enable_fuse & ~test_port_disable_bit;
  assign dmr_hit = io_sel & debug_enable_fuse & debugger_access_en;
  assign io_ordinary_sel = io_sel & ~dmr_hit;
  assign boundary_sel = (r.ir == `OP_EXTEST) || (r.ir == `OP_SAMPLE);
  assign id_word = {VERSION, PART_NUMBER, MAKER_CODE, 1'b1};
  assign debug_path_sel = port_on && (r.ir[3:2] == 2'b10);
  assign instruction = r.ir;
  assign tdo = r.tdo;
  assign tdo_oe = port_on &&
    (r.st == scan_pkg::SH_DR || r.st == scan_pkg::SH_IR);
  assign dbg_message = {r.dirty, r.msg};
  assign io_rdata = dmr_hit ? {r.dirty, r.msg} : 8'h00;
  // reset register is unlatched: a one acts this cycle
  assign system_reset = ~rst_pin_n_s | r.rst_reg | (r.tmo != 32'h0);
  // outputs released in reset, latches driven under external test
  assign pin_oe = system_reset ? '0 :
    (r.ir == `OP_EXTEST ? r.bsc_latch : core_oe);
  assign pin_out = (r.ir == `OP_EXTEST) ? r.bsc_latch : core_out;
  assign fuse_prog_grant = fuse_prog_req &
    (~(lock_bit_one | lock_bit_two) | r.erased);
  // ************************************************************
  // next state
  // ************************************************************
  always_comb
  begin
    next_r = r;
    next_r.tck_d = tck_s;
    // dirty flag: processor set wins over debugger clear
    if (dbg_read_ack)
      next_r.dirty = 1'b0;
    if (dmr_hit && io_wr)
    begin
      next_r.msg = io_wdata[6:0];
      next_r.dirty = 1'b1;
    end
    if (chip_erase_done)
      next_r.erased = 1'b1;
    if (r.rst_reg || !rst_pin_n_s)
      next_r.tmo = TIMEOUT_CYCLES[31:0];
    else if (r.tmo != 32'h0)
      next_r.tmo = r.tmo - 32'h1;
    if (!port_on)
    begin
      next_r.st = scan_pkg::TLR;
      next_r.ir = `OP_IDCODE;
    end
    else if (tck_fall)
      next_r.tdo = (r.st == scan_pkg::SH_IR) ? r.ir_sh[0] :
        (r.ir == `OP_IDCODE || boundary_sel) ? r.dr_sh[0] :
        (r.ir == `OP_SYSRST) ? r.rst_reg :
        (r.ir[3:2] == 2'b10) ? 1'b0 : r.bypass;
    else if (tck_rise)
    begin
      unique case (r.st)
        scan_pkg::TLR: next_r.st = tms_s ? scan_pkg::TLR : scan_pkg::RTI;
        scan_pkg::RTI: next_r.st = tms_s ? scan_pkg::SEL_DR : scan_pkg::RTI;
        scan_pkg::SEL_DR:
          next_r.st = tms_s ? scan_pkg::SEL_IR : scan_pkg::CAP_DR;
        scan_pkg::CAP_DR: next_r.st = tms_s ? scan_pkg::EX1_DR : scan_pkg::SH_DR;
        scan_pkg::SH_DR: next_r.st = tms_s ? scan_pkg::EX1_DR : scan_pkg::SH_DR;
        scan_pkg::EX1_DR: next_r.st = tms_s ? scan_pkg::UPD_DR : scan_pkg::PA_DR;
        scan_pkg::PA_DR: next_r.st = tms_s ? scan_pkg::EX2_DR : scan_pkg::PA_DR;
        scan_pkg::EX2_DR: next_r.st = tms_s ? scan_pkg::UPD_DR : scan_pkg::SH_DR;
        scan_pkg::UPD_DR: next_r.st = tms_s ? scan_pkg::SEL_DR : scan_pkg::RTI;
        scan_pkg::SEL_IR: next_r.st = tms_s ? scan_pkg::TLR : scan_pkg::CAP_IR;
        scan_pkg::CAP_IR: next_r.st = tms_s ? scan_pkg::EX1_IR : scan_pkg::SH_IR;
        scan_pkg::SH_IR: next_r.st = tms_s ? scan_pkg::EX1_IR : scan_pkg::SH_IR;
        scan_pkg::EX1_IR: next_r.st = tms_s ? scan_pkg::UPD_IR : scan_pkg::PA_IR;
        scan_pkg::PA_IR: next_r.st = tms_s ? scan_pkg::EX2_IR : scan_pkg::PA_IR;
        scan_pkg::EX2_IR: next_r.st = tms_s ? scan_pkg::UPD_IR : scan_pkg::SH_IR;
        scan_pkg::UPD_IR: next_r.st = tms_s ? scan_pkg::SEL_DR : scan_pkg::RTI;
        default: next_r.st = scan_pkg::TLR;
      endcase
      // actions of the state being left
      unique case (r.st)
        scan_pkg::TLR: next_r.ir = `OP_IDCODE;
        scan_pkg::CAP_IR: next_r.ir_sh = `IR_CAPTURE;
        scan_pkg::SH_IR: next_r.ir_sh = {tdi_s, r.ir_sh[3:1]};
        scan_pkg::UPD_IR: next_r.ir = r.ir_sh;
        scan_pkg::CAP_DR:
        begin
          next_r.bypass = 1'b0;
          if (r.ir == `OP_IDCODE)
            next_r.dr_sh = id_word;
          else if (boundary_sel)
            next_r.dr_sh = {24'h0, pin_in};
        end
        scan_pkg::SH_DR:
        begin
          if (r.ir == `OP_IDCODE)
            next_r.dr_sh = {tdi_s, r.dr_sh[31:1]};
          else if (boundary_sel)
            next_r.dr_sh = {24'h0, tdi_s, r.dr_sh[`BSC_LEN-1:1]};
          else if (r.ir == `OP_SYSRST)
            next_r.rst_reg = tdi_s;
          else if (r.ir[3:2] != 2'b10)
            next_r.bypass = tdi_s;
        end
        scan_pkg::UPD_DR:
          if (boundary_sel)
            next_r.bsc_latch = r.dr_sh[`BSC_LEN-1:0];
        default: next_r.bypass = r.bypass;
      endcase
    end
  end
  // ************************************************************
  // registers
  // ************************************************************
  // tck sampled on clk; a stopped core clock domain is outside this block
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      r <= '0;
      r.st <= scan_pkg::TLR;
      r.ir <= `OP_IDCODE;
    end
    else
      r <= next_r;
  end
  // ************************************************************
  // checks
  // ************************************************************
  chk_dirty_set: assert property (@(posedge clk) disable iff (sys_rst)
    (dmr_hit && io_wr) |=> r.dirty) else $error("dirty not set");
  chk_read_format: assert property (@(posedge clk) disable iff (sys_rst)
    dmr_hit |-> io_rdata == {r.dirty, r.msg}) else $error("bad read");
  chk_port_gate: assert property (@(posedge clk) disable iff (sys_rst)
    !port_on |=> r.st == scan_pkg::TLR) else $error("port not gated");
  chk_fuse_lock: assert property (@(posedge clk) disable iff (sys_rst)
    ((lock_bit_one || lock_bit_two) && !r.erased) |-> !fuse_prog_grant)
    else $error("fuse granted while locked");
  chk_reset_hiz: assert property (@(posedge clk) disable iff (sys_rst)
    system_reset |-> pin_oe == '0) else $error("pins driven in reset");
  chk_rst_reg: assert property (@(posedge clk) disable iff (sys_rst)
    r.rst_reg |-> system_reset) else $error("reset reg ignored");
  chk_timeout: assert property (@(posedge clk) disable iff (sys_rst)
    $fell(r.rst_reg) && rst_pin_n_s |-> system_reset[*4])
    else $error("no reset time-out");
  chk_extest_drive: assert property (@(posedge clk) disable iff (sys_rst)
    (r.ir == `OP_EXTEST && !system_reset) |-> pin_out == r.bsc_latch)
    else $error("extest not driving");
  chk_bypass_clr: assert property (@(posedge clk) disable iff (sys_rst)
    (tck_rise && r.st == scan_pkg::CAP_DR && port_on) |=> !r.bypass)
    else $error("bypass not cleared");
  chk_dmr_gate: assert property (@(posedge clk) disable iff (sys_rst)
    (io_sel && !debug_enable_fuse) |-> io_ordinary_sel)
    else $error("gate leak");
  cov_idcode: cover property (@(posedge clk)
    r.st == scan_pkg::SH_DR && r.ir == `OP_IDCODE);
  cov_sysrst: cover property (@(posedge clk) $rose(r.rst_reg));
  cov_extest: cover property (@(posedge clk) r.ir == `OP_EXTEST);
  cov_dirty: cover property (@(posedge clk) $fell(r.dirty));
endmodule : scan_data_regs
`default_nettype wire

// ---- tb/jtag_tester.sv ----
// boundary-scan tester model that drives the test port
`timescale 1ns/1ns
`default_nettype none
module jtag_tester
(
  // test port pins
  output logic tck,
  output logic tms,
  output logic tdi,
  input wire logic tdo
);
  // ************************************************************
  // test clock idles low between frames
  // ************************************************************
  initial
  begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b0;
  end

  // one 125 ns period; tdo sampled just before the rising edge
  task automatic step(input logic m, input logic d, output logic o);
    tms = m;
    tdi = d;
    #62;
    o = tdo;
    tck = 1'b1;
    #63;
    tck = 1'b0;
  endtask : step

  // five ones always reach reset, then park in idle
  task automatic reset_tap();
    logic o;
    repeat (5) step(1'b1, 1'b0, o);
    step(1'b0, 1'b0, o);
  endtask : reset_tap

  // shift n bits, least significant first both ways
  task automatic shift(input logic [31:0] din, input int n,
                       output logic [31:0] dout);
    logic o;
    dout = '0;
    for (int i = 0; i < n; i++)
      step(i == n - 1, din[i], dout[i]);
    step(1'b1, 1'b0, o);
    step(1'b0, 1'b0, o);
  endtask : shift

  // idle to shift-IR, four bits, back to idle
  task automatic ir_scan(input logic [3:0] op, output logic [3:0] cap);
    logic o;
    logic [31:0] w;
    step(1'b1, 1'b0, o);
    step(1'b1, 1'b0, o);
    step(1'b0, 1'b0, o);
    step(1'b0, 1'b0, o);
    shift({28'h0, op}, 4, w);
    cap = w[3:0];
  endtask : ir_scan

  // idle to shift-DR, n bits, back to idle
  task automatic dr_scan(input logic [31:0] din, input int n,
                         output logic [31:0] dout);
    logic o;
    step(1'b1, 1'b0, o);
    step(1'b0, 1'b0, o);
    step(1'b0, 1'b0, o);
    shift(din, n, dout);
  endtask : dr_scan
endmodule : jtag_tester
`default_nettype wire

// ---- tb/tb_jtag_scan_data_registers.sv ----
// self-checking bench for the test-port data registers
`timescale 1ns/1ns
`default_nettype none
`include "scan_defs.svh"
module tb_jtag_scan_data_registers;
  localparam logic [3:0] VER = 4'h3;
  localparam logic [15:0] PART = 16'h5A3C; // arbitrary value
  localparam logic [10:0] MAKER = 11'h2B5; // arbitrary value
  localparam int TOUT = 4;
  localparam int LIMIT = 40000;
  logic clk = 1'b0, sys_rst = 1'b1, ext_rst_n = 1'b1;
  logic tck, tms, tdi, tdo, tdo_oe, fuse_prog_grant, io_ordinary_sel;
  logic test_port_enable_fuse = 1'b1, test_port_disable_bit = 1'b0;
  logic debug_enable_fuse = 1'b0, debugger_access_en = 1'b0;
  logic lock_bit_one = 1'b0, lock_bit_two = 1'b0;
  logic chip_erase_done = 1'b0, fuse_prog_req = 1'b0;
  logic io_sel = 1'b0, io_wr = 1'b0, io_rd = 1'b0, dbg_read_ack = 1'b0;
  logic [7:0] io_wdata = 8'h00, pin_in = 8'h00;
  logic [7:0] core_out = 8'h00, core_oe = 8'h00;
  logic [7:0] io_rdata, dbg_message, pin_out, pin_oe, pre;
  logic system_reset, debug_path_sel;
  logic [3:0] instruction, op, cap;
  logic [31:0] w, seed = 32'hB6E562D0;
  int n_mismatch = 0, n_tests = 0, cyc = 0;

  // ************************************************************
  // clock, models and design
  // ************************************************************
  always #5 clk = ~clk;

  jtag_tester i_jtag_tester (.tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo));

  scan_data_regs #(.VERSION(VER), .PART_NUMBER(PART),
    .MAKER_CODE(MAKER), .TIMEOUT_CYCLES(TOUT)) i_scan_data_regs (
    .clk(clk),
    .sys_rst(sys_rst),
    .tck(tck),
    .tms(tms),
    .tdi(tdi),
    .tdo(tdo),
    .tdo_oe(tdo_oe),
    .test_port_enable_fuse(test_port_enable_fuse),
    .debug_enable_fuse(debug_enable_fuse),
    .lock_bit_one(lock_bit_one),
    .lock_bit_two(lock_bit_two),
    .chip_erase_done(chip_erase_done),
    .fuse_prog_req(fuse_prog_req),
    .fuse_prog_grant(fuse_prog_grant),
    .test_port_disable_bit(test_port_disable_bit),
    .debugger_access_en(debugger_access_en),
    .io_sel(io_sel),
    .io_wr(io_wr),
    .io_rd(io_rd),
    .io_wdata(io_wdata),
    .io_rdata(io_rdata),
    .io_ordinary_sel(io_ordinary_sel),
    .dbg_read_ack(dbg_read_ack),
    .dbg_message(dbg_message),
    .ext_rst_n(ext_rst_n),
    .system_reset(system_reset),
    .pin_in(pin_in),
    .core_out(core_out),
    .core_oe(core_oe),
    .pin_out(pin_out),
    .pin_oe(pin_oe),
    .debug_path_sel(debug_path_sel),
    .instruction(instruction)
  );

  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction : lfsr

  // expected two-bit scan for a one shifted in; private ops shift nothing
  function automatic logic [31:0] exp_pass(input logic [3:0] o);
    return (o >= 4'h8 && o <= 4'hB) ? 32'h0 : 32'h2;
  endfunction : exp_pass

  task automatic chk(input string what, input logic [31:0] exp,
                     input logic [31:0] got);
    n_tests++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // bounded wait for the system reset to drop
  task automatic wait_release();
    for (int n = 0; n < 30 && system_reset !== 1'b0; n++)
      @(negedge clk);
    chk("reset release", 32'h0, system_reset);
  endtask : wait_release

  task automatic end_sim();
    $display("mismatches %0d checks %0d", n_mismatch, n_tests);
    if (n_mismatch == 0 && n_tests > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : end_sim

  // hang guard, well above the expected run length
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == LIMIT)
    begin
      n_mismatch++;
      end_sim();
    end
  end

  // ************************************************************
  // scenarios
  // ************************************************************
  initial
  begin
    repeat (5) @(posedge clk);
    sys_rst <= 1'b0;
    @(negedge clk);
    chk("default ir", `OP_IDCODE, instruction);
    i_jtag_tester.reset_tap();
    i_jtag_tester.dr_scan(32'h0, 32, w);
    chk("idcode", {VER, PART, MAKER, 1'b1}, w);
    // every opcode, incl. unassigned ones that must fall to bypass
    for (int k = 0; k < 16; k++)
    begin
      op = k[3:0];
      i_jtag_tester.ir_scan(op, cap);
      chk("ir capture", 32'h1, cap);
      chk("tdo idle", 32'h0, tdo_oe);
      chk("instruction", op, instruction);
      chk("debug path", exp_pass(op) == 0, debug_path_sel);
      if (!(op inside {4'h0, 4'h1, 4'h2, 4'hC}))
      begin
        i_jtag_tester.dr_scan(32'h1, 2, w);
        chk("bypass scan", exp_pass(op), w);
      end
    end
    // snapshot and preload, then drive pins from the latches
    for (int k = 0; k < 3; k++)
    begin
      seed = lfsr(seed);
      @(posedge clk);
      pin_in <= seed[7:0];
      core_out <= seed[15:8];
      core_oe <= seed[23:16];
      pre = seed[31:24];
      i_jtag_tester.ir_scan(`OP_SAMPLE, cap);
      i_jtag_tester.dr_scan({24'h0, pre}, 8, w);
      chk("sample", pin_in, w);
      chk("pins untouched", {core_oe, core_out}, {pin_oe, pin_out});
      i_jtag_tester.ir_scan(`OP_EXTEST, cap);
      chk("extest pins", {pre, pre}, {pin_oe, pin_out});
      i_jtag_tester.dr_scan({24'h0, ~pre}, 8, w);
      chk("extest update", {~pre, ~pre}, {pin_oe, pin_out});
    end
    // reset through the one-bit reset register
    @(posedge clk);
    core_oe <= 8'hFF;
    i_jtag_tester.ir_scan(`OP_SYSRST, cap);
    i_jtag_tester.dr_scan(32'h1, 1, w);
    chk("reset reg", 32'h1, system_reset);
    chk("pins released", 32'h0, pin_oe);
    i_jtag_tester.dr_scan(32'h0, 1, w);
    wait_release();
    // reset pin, then the time-out after its release
    @(posedge clk);
    ext_rst_n <= 1'b0;
    repeat (4) @(negedge clk);
    chk("pin reset", 32'h1, system_reset);
    @(posedge clk);
    ext_rst_n <= 1'b1;
    repeat (TOUT) @(negedge clk);
    chk("reset time-out", 32'h1, system_reset);
    wait_release();
    // message register under all four gate settings
    for (int k = 0; k < 4; k++)
    begin
      seed = lfsr(seed);
      @(posedge clk);
      debug_enable_fuse <= k[0];
      debugger_access_en <= k[1];
      io_sel <= 1'b1;
      io_wr <= 1'b1;
      io_wdata <= seed[7:0];
      @(posedge clk);
      io_wr <= 1'b0;
      io_rd <= 1'b1;
      @(negedge clk);
      chk("ordinary sel", k != 3, io_ordinary_sel);
      chk("message read", k == 3 ? {1'b1, seed[6:0]} : 8'h00, io_rdata);
      @(posedge clk);
      io_sel <= 1'b0;
      io_rd <= 1'b0;
      dbg_read_ack <= 1'b1;
      @(posedge clk);
      dbg_read_ack <= 1'b0;
      @(negedge clk);
      chk("dirty cleared", 32'h0, dbg_message[7]);
    end
    // debug fuse refused under any lock bit until erased
    for (int k = 0; k < 4; k++)
    begin
      @(posedge clk);
      fuse_prog_req <= 1'b1;
      lock_bit_one <= k[0];
      lock_bit_two <= k[1];
      @(negedge clk);
      chk("fuse grant", k == 0, fuse_prog_grant);
    end
    @(posedge clk);
    chip_erase_done <= 1'b1;
    @(posedge clk);
    chip_erase_done <= 1'b0;
    @(negedge clk);
    chk("grant after erase", 32'h1, fuse_prog_grant);
    // port off by disable bit, then by the enable fuse
    for (int k = 0; k < 2; k++)
    begin
      i_jtag_tester.reset_tap();
      i_jtag_tester.ir_scan(`OP_BYPASS, cap);
      chk("port on", `OP_BYPASS, instruction);
      @(posedge clk);
      // first pass: disable bit set; second pass: enable fuse cleared
      test_port_disable_bit <= !k[0];
      test_port_enable_fuse <= !k[0];
      i_jtag_tester.ir_scan(`OP_BYPASS, cap);
      chk("port off", `OP_IDCODE, instruction);
      @(posedge clk);
      test_port_disable_bit <= 1'b0;
      test_port_enable_fuse <= 1'b1;
    end
    end_sim();
  end
endmodule : tb_jtag_scan_data_registers
`default_nettype wire
